//--- design/lmc_cfg.svh
// constants for the lane mux configuration and path-select block
`ifndef LMC_CFG_SVH
`define LMC_CFG_SVH

// stream word and lane geometry
`define LMC_WORD_W      10
`define LMC_LANES       2
`define LMC_SIDES       3
`define LMC_CHANS       6

// register-mode write addresses
`define LMC_ADDR_MISC   3'h6
`define LMC_ADDR_LAST   3'h5

// per-channel setting byte: boost, emphasis, swing
`define LMC_CH_BOOST    1:0
`define LMC_CH_EMPH     3:2
`define LMC_CH_SWING    4
`define LMC_CH_W        5

// shared control byte: rate, idle, broadcast, selects
`define LMC_MS_RATE     1:0
`define LMC_MS_IDLE     3:2
`define LMC_MS_BCAST    4
`define LMC_MS_SEL      6:5
`define LMC_MS_W        7

// boost in tenths of dB at 3 GHz (90, 135, 184)
`define LMC_BOOST_LO    8'h5A
`define LMC_BOOST_MID   8'h87
`define LMC_BOOST_HI    8'hB8

// de-emphasis depth in tenths of dB (35, 20, 60, 30, 90, 120)
`define LMC_EMPH_LO_1V0 8'h23
`define LMC_EMPH_LO_1V2 8'h14
`define LMC_EMPH_HI_1V0 8'h3C
`define LMC_EMPH_HI_1V2 8'h1E
`define LMC_EMPH_ENH_3G 8'h5A
`define LMC_EMPH_ENH_6G 8'h78

// de-emphasis pulse width in ps (330, 200, 250, 160)
`define LMC_PW_3G       9'h14A
`define LMC_PW_6G       9'h0C8
`define LMC_PW_ENH_3G   9'h0FA
`define LMC_PW_ENH_6G   9'h0A0

// output swing in mVp-p (1000, 1200)
`define LMC_SWING_1V0   11'h3E8
`define LMC_SWING_1V2   11'h4B0

`endif

//--- design/lmc_pkg.sv
// types for the lane mux configuration and path-select block
package lmc_pkg;

  // resolved level of a three-level strap
  typedef enum logic [1:0] {
    LMC_TRI_LO,
    LMC_TRI_MID,
    LMC_TRI_HI
  } lmc_tri_t;

  // control source of the block
  typedef enum logic {
    LMC_MODE_PIN,
    LMC_MODE_REG
  } lmc_mode_t;

endpackage

//--- design/lmc_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "lmc_cfg.svh"

module lmc_buf2 #(
  parameter int W = `LMC_WORD_W + 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // filling side
  input  wire logic         i_in_vld,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_rdy,
  // draining side
  output logic              o_out_vld,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_rdy
);

  logic [W-1:0] main_q;
  logic [W-1:0] skid_q;
  logic         main_vld_q;
  logic         skid_vld_q;
  wire          take = i_in_vld & ~skid_vld_q;
  wire          pop  = main_vld_q & i_out_rdy;

  // ready only drops once the skid entry is full, so no word is lost
  assign o_in_rdy   = ~skid_vld_q;
  assign o_out_vld  = main_vld_q;
  assign o_out_data = main_q;

  // entry movement
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      main_q     <= '0;
      skid_q     <= '0;
      main_vld_q <= 1'b0;
      skid_vld_q <= 1'b0;
    end else if (pop) begin
      if (skid_vld_q) begin
        main_q     <= skid_q;
        skid_vld_q <= 1'b0;
      end else begin
        main_q     <= i_in_data;
        main_vld_q <= take;
      end
    end else if (take) begin
      if (main_vld_q) begin
        skid_q     <= i_in_data;
        skid_vld_q <= 1'b1;
      end else begin
        main_q     <= i_in_data;
        main_vld_q <= 1'b1;
      end
    end
  end

endmodule

//--- design/lmc_top.sv
// lane mux configuration, strap decode and path select for two lanes
// ==========================================================
// Notes on behaviour
// - enable low means pin control, enable high means register control.
// - pin mode takes boost and emphasis from straps, one per side.
// - pin-mode enhanced emphasis raises swing to the level paired with it.
// - rate strap chooses fixed 3G, fixed 6G or automatic detection.
// - register mode sets swing, boost and emphasis per channel.
// - entering register mode moves boost/emphasis to registers; straps become address.
// - rate, idle, broadcast and select pins rule until their register is written, then until mode drops.
// - registers go to defaults at power-up and whenever enable goes low.
// - boost strap low 9 dB, float 13.5 dB, high 18.4 dB.
// - emphasis low -3.5/-2 dB, high -6/-3 dB; pulse 330 or 200 ps.
// - emphasis float: enhanced -9 dB 250 ps or -12 dB 160 ps, 1200 mV.
// - rate low 3G, high 6G, float follows the detected rate.
// - idle strap low: no idle detection, output follows input.
// - idle strap float: output idles while input is below threshold.
// - idle strap high: output forced idle, inputs ignored.
// - each lane selects A or B independently; unselected host output muted.
// - broadcast drives both host outputs; drive output still follows select.
`timescale 1ns/1ps
`include "lmc_cfg.svh"

module lmc_top (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  // mode and straps, each strap as {read with pull-down, read with pull-up}
  input  wire logic                        i_mgmt_mode_enable,
  input  wire logic [2:0][1:0]             i_boost_straps,
  input  wire logic [2:0][1:0]             i_emph_straps,
  input  wire logic [1:0]                  i_rate_strap,
  input  wire logic [1:0]                  i_idle_control_strap,
  // plain control pins
  input  wire logic                        i_broadcast_enable,
  input  wire logic                        i_lane0_path_select,
  input  wire logic                        i_lane1_path_select,
  input  wire logic                        i_swing_hi_pin,
  input  wire logic                        i_rate_detect_6g,
  // register-mode writes
  input  wire logic                        i_cfg_wr,
  input  wire logic [2:0]                  i_cfg_addr,
  input  wire logic [7:0]                  i_cfg_data,
  // host-side inputs, per lane
  input  wire logic [1:0]                  i_host_a_in_vld,
  input  wire logic [1:0][`LMC_WORD_W-1:0] i_host_a_in_data,
  input  wire logic [1:0]                  i_host_a_in_idle,
  input  wire logic [1:0]                  i_host_b_in_vld,
  input  wire logic [1:0][`LMC_WORD_W-1:0] i_host_b_in_data,
  input  wire logic [1:0]                  i_host_b_in_idle,
  output logic [1:0]                       o_drive_path_rdy,
  // drive-side output, per lane
  output logic [1:0]                       o_drive_out_vld,
  output logic [1:0][`LMC_WORD_W-1:0]      o_drive_out_data,
  output logic [1:0]                       o_drive_out_idle,
  input  wire logic [1:0]                  i_drive_out_rdy,
  // drive-side input, per lane
  input  wire logic [1:0]                  i_drive_in_vld,
  input  wire logic [1:0][`LMC_WORD_W-1:0] i_drive_in_data,
  input  wire logic [1:0]                  i_drive_in_idle,
  // host-side outputs, per lane
  output logic [1:0]                       o_host_a_out_vld,
  output logic [1:0][`LMC_WORD_W-1:0]      o_host_a_out_data,
  output logic [1:0]                       o_host_a_out_idle,
  output logic [1:0]                       o_host_b_out_vld,
  output logic [1:0][`LMC_WORD_W-1:0]      o_host_b_out_data,
  output logic [1:0]                       o_host_b_out_idle,
  // resolved settings, per channel
  output logic [5:0][7:0]                  o_boost_db10,
  output logic [5:0][7:0]                  o_emph_db10,
  output logic [5:0][8:0]                  o_emph_ps,
  output logic [5:0][10:0]                 o_swing_mv,
  // status
  output logic                             o_reg_mode,
  output logic                             o_rate_6g,
  output logic [3:0]                       o_bus_address_inputs
);

  // ==========================================================
  // decode functions

  function automatic lmc_pkg::lmc_tri_t tri_of(input logic [1:0] s);
    case (s)
      2'b00:   tri_of = lmc_pkg::LMC_TRI_LO;
      2'b11:   tri_of = lmc_pkg::LMC_TRI_HI;
      default: tri_of = lmc_pkg::LMC_TRI_MID;
    endcase
  endfunction

  function automatic logic [7:0] boost_db10(input lmc_pkg::lmc_tri_t c);
    case (c)
      lmc_pkg::LMC_TRI_LO: boost_db10 = `LMC_BOOST_LO;
      lmc_pkg::LMC_TRI_HI: boost_db10 = `LMC_BOOST_HI;
      default:             boost_db10 = `LMC_BOOST_MID;
    endcase
  endfunction

  function automatic logic [7:0] emph_db10(input lmc_pkg::lmc_tri_t c,
                                           input logic sw_hi, input logic r6);
    case (c)
      lmc_pkg::LMC_TRI_LO: emph_db10 = sw_hi ? `LMC_EMPH_LO_1V2 : `LMC_EMPH_LO_1V0;
      lmc_pkg::LMC_TRI_HI: emph_db10 = sw_hi ? `LMC_EMPH_HI_1V2 : `LMC_EMPH_HI_1V0;
      default:             emph_db10 = r6 ? `LMC_EMPH_ENH_6G : `LMC_EMPH_ENH_3G;
    endcase
  endfunction

  function automatic logic [8:0] emph_ps(input lmc_pkg::lmc_tri_t c, input logic r6);
    case (c)
      lmc_pkg::LMC_TRI_MID: emph_ps = r6 ? `LMC_PW_ENH_6G : `LMC_PW_ENH_3G;
      default:              emph_ps = r6 ? `LMC_PW_6G : `LMC_PW_3G;
    endcase
  endfunction

  function automatic logic idle_of(input lmc_pkg::lmc_tri_t c, input logic in_idle);
    case (c)
      lmc_pkg::LMC_TRI_LO: idle_of = 1'b0;
      lmc_pkg::LMC_TRI_HI: idle_of = 1'b1;
      default:             idle_of = in_idle;
    endcase
  endfunction

  // ==========================================================
  // mode and register file

  lmc_pkg::lmc_mode_t          mode_q;
  logic [5:0][`LMC_CH_W-1:0]   chan_q;
  logic [`LMC_MS_W-1:0]        misc_q;
  logic                        misc_wr_q;
  wire                         reg_mode = (mode_q == lmc_pkg::LMC_MODE_REG);
  wire                         wr_chan  = reg_mode & i_cfg_wr & (i_cfg_addr <= `LMC_ADDR_LAST);
  wire                         wr_misc  = reg_mode & i_cfg_wr & (i_cfg_addr == `LMC_ADDR_MISC);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= lmc_pkg::LMC_MODE_PIN;
    end else begin
      mode_q <= i_mgmt_mode_enable ? lmc_pkg::LMC_MODE_REG : lmc_pkg::LMC_MODE_PIN;
    end
  end

  // defaults at reset and throughout pin mode
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chan_q    <= '0;
      misc_q    <= '0;
      misc_wr_q <= 1'b0;
    end else if (!reg_mode) begin
      chan_q    <= '0;
      misc_q    <= '0;
      misc_wr_q <= 1'b0;
    end else begin
      if (wr_chan) begin
        chan_q[i_cfg_addr] <= i_cfg_data[`LMC_CH_W-1:0];
      end
      if (wr_misc) begin
        misc_q    <= i_cfg_data[`LMC_MS_W-1:0];
        misc_wr_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // shared controls: pins until the control register is written

  wire       use_misc = reg_mode & misc_wr_q;
  wire [1:0] rate_src = use_misc ? misc_q[`LMC_MS_RATE] : i_rate_strap;
  wire [1:0] idle_src = use_misc ? misc_q[`LMC_MS_IDLE] : i_idle_control_strap;
  wire       bcast    = use_misc ? misc_q[`LMC_MS_BCAST] : i_broadcast_enable;
  wire [1:0] sel      = use_misc ? misc_q[`LMC_MS_SEL]
                                 : {i_lane1_path_select, i_lane0_path_select};

  lmc_pkg::lmc_tri_t rate_code;
  lmc_pkg::lmc_tri_t idle_code;
  assign rate_code = tri_of(rate_src);
  assign idle_code = tri_of(idle_src);
  wire   rate_6g   = (rate_code == lmc_pkg::LMC_TRI_HI) |
                     ((rate_code == lmc_pkg::LMC_TRI_MID) & i_rate_detect_6g);

  // ==========================================================
  // per-channel settings: 0-1 host A, 2-3 host B, 4-5 drive side

  logic [5:0][7:0]  boost_d;
  logic [5:0][7:0]  emph_d;
  logic [5:0][8:0]  pw_d;
  logic [5:0][10:0] swing_d;

  for (genvar c = 0; c < `LMC_CHANS; c++) begin : g_chan
    lmc_pkg::lmc_tri_t b_code;
    lmc_pkg::lmc_tri_t e_code;
    // straps per side in pin mode, registers per channel after
    assign b_code = reg_mode ? tri_of(chan_q[c][`LMC_CH_BOOST]) : tri_of(i_boost_straps[c/2]);
    assign e_code = reg_mode ? tri_of(chan_q[c][`LMC_CH_EMPH]) : tri_of(i_emph_straps[c/2]);
    // enhanced setting forces the high swing
    wire   sw_hi  = (e_code == lmc_pkg::LMC_TRI_MID) |
                    (reg_mode ? chan_q[c][`LMC_CH_SWING] : i_swing_hi_pin);
    assign boost_d[c] = boost_db10(b_code);
    assign emph_d[c]  = emph_db10(e_code, sw_hi, rate_6g);
    assign pw_d[c]    = emph_ps(e_code, rate_6g);
    // swing never below 1000 mV while emphasis is active
    assign swing_d[c] = sw_hi ? `LMC_SWING_1V2 : `LMC_SWING_1V0;
  end

  // address pins take the strap level, float reads low via pull-down
  wire [3:0] addr_d = reg_mode ? {i_emph_straps[0][1], i_boost_straps[2][1],
                                  i_boost_straps[1][1], i_boost_straps[0][1]} : 4'h0;

  // settings and status registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boost_db10         <= '0;
      o_emph_db10          <= '0;
      o_emph_ps            <= '0;
      o_swing_mv           <= '0;
      o_reg_mode           <= 1'b0;
      o_rate_6g            <= 1'b0;
      o_bus_address_inputs <= 4'h0;
    end else begin
      o_boost_db10         <= boost_d;
      o_emph_db10          <= emph_d;
      o_emph_ps            <= pw_d;
      o_swing_mv           <= swing_d;
      o_reg_mode           <= reg_mode;
      o_rate_6g            <= rate_6g;
      o_bus_address_inputs <= addr_d;
    end
  end

  // ==========================================================
  // lane data paths

  logic [1:0]                  ha_vld_d;
  logic [1:0]                  hb_vld_d;
  logic [1:0]                  ha_idle_d;
  logic [1:0]                  hb_idle_d;
  logic [1:0][`LMC_WORD_W-1:0] ha_data_d;
  logic [1:0][`LMC_WORD_W-1:0] hb_data_d;
  wire                         forced = (idle_code == lmc_pkg::LMC_TRI_HI);

  for (genvar l = 0; l < `LMC_LANES; l++) begin : g_lane
    wire                   s_vld  = sel[l] ? i_host_a_in_vld[l] : i_host_b_in_vld[l];
    wire [`LMC_WORD_W-1:0] s_data = sel[l] ? i_host_a_in_data[l] : i_host_b_in_data[l];
    wire                   s_idle = sel[l] ? i_host_a_in_idle[l] : i_host_b_in_idle[l];
    // forced idle zeroes the data of the input word
    wire [`LMC_WORD_W:0]   s_word = {idle_of(idle_code, s_idle),
                                     forced ? '0 : s_data};
    wire [`LMC_WORD_W:0]   o_word;

    // buffer so a stalled drive receiver loses no word
    lmc_buf2 #(
      .W (`LMC_WORD_W + 1)
    ) u_buf (
      .i_clk      (i_clk),
      .i_arst_n   (i_arst_n),
      .i_in_vld   (s_vld),
      .i_in_data  (s_word),
      .o_in_rdy   (o_drive_path_rdy[l]),
      .o_out_vld  (o_drive_out_vld[l]),
      .o_out_data (o_word),
      .i_out_rdy  (i_drive_out_rdy[l])
    );
    assign o_drive_out_data[l] = o_word[`LMC_WORD_W-1:0];
    assign o_drive_out_idle[l] = o_word[`LMC_WORD_W];

    // mute unselected host output unless broadcasting
    wire a_on = sel[l] | bcast;
    wire b_on = ~sel[l] | bcast;
    wire d_idle = idle_of(idle_code, i_drive_in_idle[l]);
    wire [`LMC_WORD_W-1:0] d_data = forced ? '0 : i_drive_in_data[l];
    assign ha_vld_d[l]  = a_on & i_drive_in_vld[l];
    assign hb_vld_d[l]  = b_on & i_drive_in_vld[l];
    assign ha_idle_d[l] = a_on ? d_idle : 1'b1;
    assign hb_idle_d[l] = b_on ? d_idle : 1'b1;
    assign ha_data_d[l] = a_on ? d_data : '0;
    assign hb_data_d[l] = b_on ? d_data : '0;
  end

  // host output registers, muted and idle from reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_host_a_out_vld  <= '0;
      o_host_b_out_vld  <= '0;
      o_host_a_out_idle <= '1;
      o_host_b_out_idle <= '1;
      o_host_a_out_data <= '0;
      o_host_b_out_data <= '0;
    end else begin
      o_host_a_out_vld  <= ha_vld_d;
      o_host_b_out_vld  <= hb_vld_d;
      o_host_a_out_idle <= ha_idle_d;
      o_host_b_out_idle <= hb_idle_d;
      o_host_a_out_data <= ha_data_d;
      o_host_b_out_data <= hb_data_d;
    end
  end

endmodule

//--- testbench/lmc_top_chk.sv
// port checker for lmc_top, bound onto every instance
`timescale 1ns/1ps
`include "lmc_cfg.svh"
module lmc_top_chk (
  // clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_arst_n,
  // watched inputs
  input wire logic                   i_mgmt_mode_enable,
  input wire logic [2:0][1:0]        i_boost_straps,
  input wire logic [2:0][1:0]        i_emph_straps,
  input wire logic [1:0]             i_rate_strap,
  input wire logic [1:0]             i_idle_control_strap,
  input wire logic                   i_broadcast_enable,
  input wire logic                   i_lane0_path_select,
  input wire logic                   i_swing_hi_pin,
  input wire logic                   i_rate_detect_6g,
  input wire logic [1:0]             i_drive_in_vld,
  input wire logic [1:0][9:0]        i_drive_in_data,
  input wire logic [1:0]             i_drive_out_rdy,
  // watched outputs
  input wire logic [1:0]             o_drive_out_vld,
  input wire logic [1:0][9:0]        o_drive_out_data,
  input wire logic [1:0]             o_host_b_out_vld,
  input wire logic [1:0][9:0]        o_host_b_out_data,
  input wire logic [1:0]             o_host_b_out_idle,
  input wire logic [5:0][7:0]        o_boost_db10,
  input wire logic [5:0][7:0]        o_emph_db10,
  input wire logic [5:0][10:0]       o_swing_mv,
  input wire logic                   o_reg_mode,
  input wire logic                   o_rate_6g
);
  logic [2:0]       pin_q;
  logic             e6;
  logic [5:0][7:0]  eb, ee;
  logic [5:0][10:0] es;
  int               b, d;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  function automatic int lv(input logic [1:0] s);
    return (s == 2'b00) ? 0 : (s == 2'b11) ? 2 : 1;
  endfunction
  // ========================================
  // trust pin mode after four low edges, so mode lag trips no check
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) pin_q <= 3'd0;
    else if (i_mgmt_mode_enable) pin_q <= 3'd0;
    else if (pin_q != 3'd4) pin_q <= pin_q + 3'd1;
  end
  // expected pin decode per channel
  always_comb begin
    e6 = lv(i_rate_strap) == 2 || (lv(i_rate_strap) == 1 && i_rate_detect_6g);
    for (int c = 0; c < 6; c++) begin
      b = lv(i_boost_straps[c/2]);
      d = lv(i_emph_straps[c/2]);
      eb[c] = (b == 0) ? `LMC_BOOST_LO : (b == 1) ? `LMC_BOOST_MID : `LMC_BOOST_HI;
      es[c] = (d == 1 || i_swing_hi_pin) ? `LMC_SWING_1V2 : `LMC_SWING_1V0;
      ee[c] = (d == 1) ? (e6 ? `LMC_EMPH_ENH_6G : `LMC_EMPH_ENH_3G) :
              (d == 0) ? (i_swing_hi_pin ? `LMC_EMPH_LO_1V2 : `LMC_EMPH_LO_1V0) :
              (i_swing_hi_pin ? `LMC_EMPH_HI_1V2 : `LMC_EMPH_HI_1V0);
    end
  end
  a_mode_enter: assert property ($rose(i_mgmt_mode_enable) |-> ##[1:2] o_reg_mode)
    else $error("register mode not entered");
  a_mode_leave: assert property ($fell(i_mgmt_mode_enable) |-> ##[1:2] !o_reg_mode)
    else $error("register mode not left");
  a_boost_pin: assert property (pin_q == 3'd4 && $stable(i_boost_straps) |-> o_boost_db10 == eb)
    else $error("boost decode wrong");
  a_emph_swing: assert property (pin_q == 3'd4 && $stable({i_emph_straps, i_swing_hi_pin,
    i_rate_strap, i_rate_detect_6g}) |-> o_emph_db10 == ee && o_swing_mv == es)
    else $error("emphasis or swing decode wrong");
  a_rate_pin: assert property (pin_q == 3'd4 && $stable({i_rate_strap, i_rate_detect_6g})
    |-> o_rate_6g == e6)
    else $error("rate decode wrong");
  a_host_route: assert property (pin_q == 3'd4 && i_idle_control_strap == 2'b00 && $stable({
    i_idle_control_strap, i_lane0_path_select, i_broadcast_enable}) |-> o_host_b_out_vld[0] ==
    $past(i_drive_in_vld[0] & (~i_lane0_path_select | i_broadcast_enable)))
    else $error("host b lane0 routing wrong");
  a_forced_idle: assert property (pin_q == 3'd4 && i_idle_control_strap == 2'b11 &&
    $past(i_idle_control_strap) == 2'b11 |-> &o_host_b_out_idle && o_host_b_out_data == '0)
    else $error("forced idle not applied");
  a_drive_hold: assert property (o_drive_out_vld[0] && !i_drive_out_rdy[0] |=>
    o_drive_out_vld[0] && $stable(o_drive_out_data[0]))
    else $error("stalled drive word lost");
  c_stall: cover property (o_drive_out_vld[0] && !i_drive_out_rdy[0]);
  c_reg: cover property ($rose(o_reg_mode));
  c_idle: cover property (pin_q == 3'd4 && i_idle_control_strap == 2'b11);
endmodule

bind lmc_top lmc_top_chk u_lmc_top_chk (.i_clk, .i_arst_n, .i_mgmt_mode_enable, .i_boost_straps,
  .i_emph_straps, .i_rate_strap, .i_idle_control_strap, .i_broadcast_enable, .i_lane0_path_select,
  .i_swing_hi_pin, .i_rate_detect_6g, .i_drive_in_vld, .i_drive_in_data, .i_drive_out_rdy,
  .o_drive_out_vld, .o_drive_out_data, .o_host_b_out_vld, .o_host_b_out_data, .o_host_b_out_idle,
  .o_boost_db10, .o_emph_db10, .o_swing_mv, .o_reg_mode, .o_rate_6g);

//--- testbench/lmc_drive_model.sv
// drive-side receiver model, ready every edge or one edge in four
`timescale 1ns/1ps
module lmc_drive_model (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_arst_n,
  // pacing and drive-side stream
  input  wire logic            i_slow,
  input  wire logic [1:0]      i_vld,
  input  wire logic [1:0][9:0] i_data,
  output logic [1:0]           o_rdy
);
  logic [1:0] ph_q;
  logic [9:0] got[2][$];
  // ========================================
  // log words where valid meets ready; slow pacing fills the buffer
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ph_q <= 2'd0;
      o_rdy <= 2'b00;
    end else begin
      ph_q <= ph_q + 2'd1;
      o_rdy <= {2{!i_slow || ph_q == 2'd3}};
      for (int l = 0; l < 2; l++) if (i_vld[l] && o_rdy[l]) got[l].push_back(i_data[l]);
    end
  end
endmodule

//--- testbench/lane_mux_config_control_test.sv
// self-checking bench for the lane mux configuration block
`timescale 1ns/1ps
`include "lmc_cfg.svh"
module lane_mux_config_control_test;
  logic            clk, rst_n, men, bc, s0, s1, swh, det, wr, slow, regm, r6;
  logic [2:0]      adr;
  logic [7:0]      wd;
  logic [3:0]      bai;
  logic [2:0][1:0] bst, emp;
  logic [1:0]      rate, idl, av, ai, bv, bi, dv, di, prdy, dov, doi, drdy, hav, hai, hbv, hbi;
  logic [1:0][9:0] ad, bd, dd, dod, had, hbd;
  logic [5:0][7:0] boo, emd;
  logic [5:0][8:0] eps;
  logic [5:0][10:0] swm;
  int              mismatches = 0, samples_checked = 0, cyc = 0;
  // ========================================
  // design and drive-side partner
  lmc_top u_lmc_top (.i_clk(clk), .i_arst_n(rst_n), .i_mgmt_mode_enable(men),
    .i_boost_straps(bst), .i_emph_straps(emp), .i_rate_strap(rate), .i_idle_control_strap(idl),
    .i_broadcast_enable(bc), .i_lane0_path_select(s0), .i_lane1_path_select(s1),
    .i_swing_hi_pin(swh), .i_rate_detect_6g(det), .i_cfg_wr(wr), .i_cfg_addr(adr),
    .i_cfg_data(wd), .i_host_a_in_vld(av), .i_host_a_in_data(ad), .i_host_a_in_idle(ai),
    .i_host_b_in_vld(bv), .i_host_b_in_data(bd), .i_host_b_in_idle(bi),
    .o_drive_path_rdy(prdy), .o_drive_out_vld(dov), .o_drive_out_data(dod),
    .o_drive_out_idle(doi), .i_drive_out_rdy(drdy), .i_drive_in_vld(dv), .i_drive_in_data(dd),
    .i_drive_in_idle(di), .o_host_a_out_vld(hav), .o_host_a_out_data(had),
    .o_host_a_out_idle(hai), .o_host_b_out_vld(hbv), .o_host_b_out_data(hbd),
    .o_host_b_out_idle(hbi), .o_boost_db10(boo), .o_emph_db10(emd), .o_emph_ps(eps),
    .o_swing_mv(swm), .o_reg_mode(regm), .o_rate_6g(r6), .o_bus_address_inputs(bai));
  lmc_drive_model u_lmc_drive_model (.i_clk(clk), .i_arst_n(rst_n), .i_slow(slow),
    .i_vld(dov), .i_data(dod), .o_rdy(drdy));
  // clock, and a hang cut off far past the few hundred cycles needed
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end
  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // float coded both ways: either pull reading is mid level
  function automatic logic [1:0] enc(input int l, input bit alt);
    return (l == 0) ? 2'b00 : (l == 2) ? 2'b11 : (alt ? 2'b10 : 2'b01);
  endfunction
  // ========================================
  // pin decode over all strap levels, swing and rate, sides differing
  task automatic t_pin();
    int s, e6;
    for (int l = 0; l < 18; l++) begin
      for (int k = 0; k < 3; k++) begin
        bst[k] = enc((l / 6 + k) % 3, k[0]);
        emp[k] = enc((l / 6 + k) % 3, ~k[0]);
      end
      swh = l[0];
      det = ~l[0];
      rate = enc((l / 2) % 3, l[0]);
      e6 = ((l / 2) % 3 == 2) || ((l / 2) % 3 == 1 && det);
      tick(2);
      chk(r6, e6);
      for (int c = 0; c < 6; c++) begin
        s = (l / 6 + c / 2) % 3;
        chk(boo[c], s == 0 ? `LMC_BOOST_LO : s == 1 ? `LMC_BOOST_MID : `LMC_BOOST_HI);
        chk(swm[c], (s == 1 || swh) ? `LMC_SWING_1V2 : `LMC_SWING_1V0);
        chk(eps[c], s == 1 ? (e6 ? `LMC_PW_ENH_6G : `LMC_PW_ENH_3G) :
          (e6 ? `LMC_PW_6G : `LMC_PW_3G));
        chk(emd[c], s == 1 ? (e6 ? `LMC_EMPH_ENH_6G : `LMC_EMPH_ENH_3G) : s == 0 ?
          (swh ? `LMC_EMPH_LO_1V2 : `LMC_EMPH_LO_1V0) :
          (swh ? `LMC_EMPH_HI_1V2 : `LMC_EMPH_HI_1V0));
      end
    end
  endtask
  // one drive-side word on lane 0, landing checked a cycle later
  task automatic pr(input logic a, input logic b);
    dv = 2'b01;
    dd[0] = 10'h2AA;
    tick(1);
    dv = 2'b00;
    chk(hav[0], a);
    chk(hbv[0], b);
  endtask
  // every broadcast and select combination, both lanes at once
  task automatic t_route();
    idl = 2'b00;
    for (int m = 0; m < 8; m++) begin
      {bc, s1, s0} = m[2:0];
      tick(2);
      dv = 2'b11;
      dd = {10'h200 + 10'(m), 10'h100 + 10'(m)};
      tick(1);
      chk(hav, {s1 | bc, s0 | bc});
      chk(hbv, {~s1 | bc, ~s0 | bc});
      chk(hai, {~(s1 | bc), ~(s0 | bc)});
      chk(had[1], (s1 | bc) ? dd[1] : 10'h000);
      chk(hbd[0], (~s0 | bc) ? dd[0] : 10'h000);
      dv = 2'b00;
    end
    bc = 1'b0;
  endtask
  // idle strap low, float and high on lane 0 host A
  task automatic t_idle();
    {s1, s0} = 2'b11;
    for (int l = 0; l < 3; l++) begin
      idl = enc(l, 1'b0);
      tick(2);
      dv = 2'b11;
      di = (l == 1) ? 2'b01 : 2'b00;
      dd[0] = 10'h155;
      tick(1);
      chk(hai[0], l != 0);
      chk(hai[1], l == 2);
      if (l != 1) chk(had[0], (l == 0) ? 10'h155 : 10'h000);
      {dv, di} = '0;
    end
    idl = 2'b00;
  endtask
  // six host words into a slow receiver: fill, refuse, drain
  task automatic t_drive(input int ln);
    int  n, rf;
    s0 = 1'b1;
    s1 = 1'b0;
    {slow, idl, ai, bi} = 7'h5F; // float idle, host idle high
    rf = 0;
    tick(2);
    for (int k = 0; k < 6; k++) begin
      av[ln] = 1'b1;
      bv[ln] = 1'b1;
      ad[ln] = 10'h0A0 + 10'(k);
      bd[ln] = 10'h1B0 + 10'(k);
      n = 0;
      while (prdy[ln] !== 1'b1 && n < 50) begin
        rf = 1;
        tick(1);
        n++;
      end
      tick(1);
    end
    {av, bv} = '0;
    n = 0;
    while (u_lmc_drive_model.got[ln].size() < 6 && n < 200) begin
      tick(1);
      n++;
    end
    chk(rf, 1'b1);
    chk(u_lmc_drive_model.got[ln].size(), 6);
    for (int k = 0; k < 6; k++) chk(u_lmc_drive_model.got[ln][k], (ln ? 10'h1B0 : 10'h0A0) + k);
    chk(dov[ln], 1'b0);
    chk(doi[ln], 1'b1);
    slow = 1'b0;
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    wr = 1'b1;
    adr = a;
    wd = d;
    tick(1);
    wr = 1'b0;
    tick(2);
  endtask
  // register mode: address pins, lane writes, shared pins, exit clear
  task automatic t_reg();
    bst = {2'b00, 2'b11, 2'b10};
    emp[0] = 2'b11;
    {rate, s0, swh} = '0;
    men = 1'b1;
    tick(3);
    chk(regm, 1'b1);
    chk(bai, 4'hB);
    chk(boo[2], `LMC_BOOST_LO);
    chk(swm[2], `LMC_SWING_1V0);
    wrr(3'h0, 8'h13);
    chk(boo[0], `LMC_BOOST_HI);
    chk(emd[0], `LMC_EMPH_LO_1V2);
    chk(swm[0], `LMC_SWING_1V2);
    chk(boo[1], `LMC_BOOST_LO);
    s0 = 1'b1;
    tick(2);
    pr(1'b1, 1'b0);
    wrr(`LMC_ADDR_MISC, 8'h00);
    pr(1'b0, 1'b1);
    men = 1'b0;
    tick(3);
    chk(regm, 1'b0);
    chk(bai, 4'h0);
    wrr(3'h0, 8'h13);
    chk(boo[0], `LMC_BOOST_MID);
    men = 1'b1;
    tick(3);
    chk(boo[0], `LMC_BOOST_LO);
    pr(1'b1, 1'b0);
    men = 1'b0;
    tick(3);
  endtask
  // ========================================
  // reset for six cycles, then the scenarios in turn
  initial begin
    {men, bc, s0, s1, swh, det, wr, slow, av, ai, bv, bi, dv, di, rate, adr, wd} = '0;
    {ad, bd, dd, bst, emp} = '0;
    idl = 2'b01;
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(1);
    t_pin();
    t_route();
    t_idle();
    t_drive(0);
    t_drive(1);
    t_reg();
    test_done();
  end
endmodule
